// file: src/tfs_consts.svh
`ifndef TFS_CONSTS_SVH
`define TFS_CONSTS_SVH

// opcodes
`define TFS_OP_TERM_SETUP 8'hA0
`define TFS_OP_FEAT_WRITE 8'hEF
`define TFS_OP_LUN_FEAT_WRITE 8'hD5
`define TFS_OP_RESET_FULL 8'hFF
`define TFS_OP_RESET_SYNC 8'hFC
`define TFS_OP_RESET_LUN 8'hFA

// feature selectors and fields
`define TFS_FEAT_TIMING 8'h01
`define TFS_TM_IFACE_LSB 4
`define TFS_TM_NUM_LSB 0

// termination setup payload
`define TFS_TERM_IDX_M0 3'h0
`define TFS_TERM_IDX_M1 3'h1
`define TFS_TERM_IDX_DS 3'h2
`define TFS_TERM_IDX_RE 3'h3
`define TFS_TERM_IDX_LAST 3'h5
`define TFS_LUN_LSB 0
`define TFS_DS_OUT_LSB 4
`define TFS_DS_IN_LSB 0
`define TFS_RE_LSB 0
`define TFS_FEAT_IDX_LAST 2'h3

// reset values
`define TFS_MATRIX_RST 16'h0000
`define TFS_TERM_BYTE_RST 8'h00
`define TFS_TM_NUM_RST 4'h0
`define TFS_HAS_30_OHM 1'b1

// busy times
`define TFS_CLK_MHZ 125
`define TFS_FEAT_BUSY_NS 1000
`define TFS_ITC_BUSY_NS 1000
`define TFS_FEAT_BUSY_CYC ((`TFS_FEAT_BUSY_NS * `TFS_CLK_MHZ + 999) / 1000)
`define TFS_ITC_BUSY_CYC ((`TFS_ITC_BUSY_NS * `TFS_CLK_MHZ + 999) / 1000)

`endif

// file: src/tfs_pkg.sv
package tfs_pkg;
  typedef enum logic [1:0] {
    TFS_CYC_CMD = 2'b00,
    TFS_CYC_ADDR = 2'b01,
    TFS_CYC_DATA = 2'b10,
    TFS_CYC_NONE = 2'b11
  } tfs_cyc_kind_t;

  typedef struct packed {
    tfs_cyc_kind_t kind;
    logic [15:0] bus;
  } tfs_cyc_t;

  typedef enum logic [1:0] {
    TFS_IF_SDR = 2'b00,
    TFS_IF_DDR_V1 = 2'b01,
    TFS_IF_DDR_V2 = 2'b10,
    TFS_IF_RSVD = 2'b11
  } tfs_iface_t;

  typedef enum logic [2:0] {
    TFS_RTT_OFF = 3'b000,
    TFS_RTT_150 = 3'b001,
    TFS_RTT_100 = 3'b010,
    TFS_RTT_75 = 3'b011,
    TFS_RTT_50 = 3'b100,
    TFS_RTT_30 = 3'b101
  } tfs_rtt_t;

  typedef struct packed {
    logic [15:0] matrix;
    logic [7:0] data_strobe_term_byte;
    logic [7:0] read_enable_term_byte;
  } tfs_term_cfg_t;

  typedef struct packed {
    logic [7:0] feature_selector;
    logic [31:0] feature_param_bytes;
  } tfs_feat_t;

  typedef enum logic [2:0] {
    TFS_ST_IDLE = 3'b000,
    TFS_ST_TERM_LUN = 3'b001,
    TFS_ST_TERM_PAY = 3'b010,
    TFS_ST_FEAT_LUN = 3'b011,
    TFS_ST_FEAT_SEL = 3'b100,
    TFS_ST_FEAT_PAR = 3'b101,
    TFS_ST_BUSY = 3'b110
  } tfs_state_t;
endpackage

// file: src/tfs_busy_timer.sv
`timescale 1ns/100ps
`include "tfs_consts.svh"

module tfs_busy_timer (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic long_sel,
  input wire logic abort,
  // status
  output logic busy
);
  localparam logic [11:0] FEAT_CYC = 12'(`TFS_FEAT_BUSY_CYC);
  localparam logic [11:0] ITC_CYC = 12'(`TFS_ITC_BUSY_CYC);

  logic [11:0] cnt_q;
  logic busy_q;
  logic [11:0] len_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 12'h000;
      busy_q <= 1'b0;
    end else if (abort) begin
      cnt_q <= 12'h000;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= (long_sel ? ITC_CYC : FEAT_CYC) - 12'h001;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == 12'h000) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 12'h001;
      end
    end
  end

  assign busy = busy_q;

  // helper: length of the current busy window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_q <= 12'h000;
    end else if (start) begin
      len_q <= 12'h001;
    end else if (busy_q) begin
      len_q <= len_q + 12'h001;
    end
  end

  a_busy_length: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(busy_q) && !$past(abort) && !$past(start))
      |-> (len_q == FEAT_CYC + 12'h001 || len_q == ITC_CYC + 12'h001))
    else $error("busy window length wrong");
endmodule // tfs_busy_timer

// file: src/tfs_cmd_top.sv
`timescale 1ns/100ps
`include "tfs_consts.svh"

// Behaviour
// - terminator LUN terminates during volume data cycles
// - configured volume applies matrix from then on
// - matrix resets to 0000h, termination off
// - double-rate payload bytes latched once only
// - second double-rate: new values apply at once
// - termination settings survive every reset command
// - LUN byte decoded like row address LUN
// - matrix bit n terminates volume n
// - term bytes: output/input nibbles, read-enable nibble
// - nibble codes 0-5 map to ohms, rest reserved
// - input field on writes, output field on reads
// - feature parameters only on low eight lines
// - EFh whole target, D5h addressed LUN only
// - timing change uses interface change busy time
// - selector then four parameter bytes
// - per-LUN address byte holds LUN bits 2:0
// - data interface field: SDR, v1, v2, reserved
module tfs_cmd_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus cycles from the pin front end
  input wire logic cyc_valid,
  input tfs_pkg::tfs_cyc_t cyc,
  // identity of this LUN
  input wire logic [2:0] own_lun,
  // volume activity
  input wire logic [3:0] act_volume,
  input wire logic act_data_in,
  input wire logic act_data_out,
  // termination drive
  output logic odt_on,
  output tfs_pkg::tfs_rtt_t odt_data_strobe_rtt,
  output tfs_pkg::tfs_rtt_t odt_read_enable_rtt,
  // settings and status
  output tfs_pkg::tfs_term_cfg_t term_cfg,
  output logic vol_term_active,
  output tfs_pkg::tfs_iface_t data_iface,
  output logic [3:0] timing_mode_num,
  output tfs_pkg::tfs_feat_t feat_last,
  output logic feat_write_pulse,
  output logic ready
);
  tfs_pkg::tfs_state_t state_q;
  tfs_pkg::tfs_term_cfg_t term_q;
  tfs_pkg::tfs_term_cfg_t stage_q;
  tfs_pkg::tfs_feat_t feat_q;
  tfs_pkg::tfs_feat_t fstage_q;
  tfs_pkg::tfs_iface_t iface_q;
  logic [3:0] tm_num_q;
  logic vol_cfg_q;
  logic lun_hit_q;
  logic [2:0] idx_q;
  logic [1:0] fidx_q;
  logic skip_q;
  logic feat_pulse_q;
  logic busy_start;
  logic busy_long;
  logic timer_busy;
  logic is_cmd;
  logic is_addr;
  logic is_data;
  logic dup_on;
  logic take_data;
  logic reset_cmd;
  logic full_reset;
  logic [7:0] byte_lo;
  logic term_last;
  logic feat_last_byte;
  logic [2:0] lun_field;

  function automatic tfs_pkg::tfs_rtt_t rtt_decode(input logic [3:0] code);
    unique case (code)
      4'h0: rtt_decode = tfs_pkg::TFS_RTT_OFF;
      4'h1: rtt_decode = tfs_pkg::TFS_RTT_150;
      4'h2: rtt_decode = tfs_pkg::TFS_RTT_100;
      4'h3: rtt_decode = tfs_pkg::TFS_RTT_75;
      4'h4: rtt_decode = tfs_pkg::TFS_RTT_50;
      4'h5: rtt_decode = `TFS_HAS_30_OHM ? tfs_pkg::TFS_RTT_30 : tfs_pkg::TFS_RTT_OFF;
      // reserved codes leave the pin unterminated rather than guess
      default: rtt_decode = tfs_pkg::TFS_RTT_OFF;
    endcase
  endfunction

  // parameters ride on the low lane; upper lines are ignored
  assign byte_lo = cyc.bus[7:0];
  assign is_cmd = cyc_valid && cyc.kind == tfs_pkg::TFS_CYC_CMD;
  assign is_addr = cyc_valid && cyc.kind == tfs_pkg::TFS_CYC_ADDR;
  assign is_data = cyc_valid && cyc.kind == tfs_pkg::TFS_CYC_DATA;
  assign reset_cmd = is_cmd && (byte_lo == `TFS_OP_RESET_FULL ||
                                byte_lo == `TFS_OP_RESET_SYNC ||
                                byte_lo == `TFS_OP_RESET_LUN);
  assign full_reset = is_cmd && byte_lo == `TFS_OP_RESET_FULL;
  assign lun_field = byte_lo[`TFS_LUN_LSB +: 3];

  // setup duplicates only on v2; feature writes on either ddr
  assign dup_on = (state_q == tfs_pkg::TFS_ST_TERM_PAY) ?
                  (iface_q == tfs_pkg::TFS_IF_DDR_V2) :
                  (iface_q != tfs_pkg::TFS_IF_SDR);
  assign take_data = is_data && !(dup_on && skip_q);
  assign term_last = take_data && state_q == tfs_pkg::TFS_ST_TERM_PAY &&
                     idx_q == `TFS_TERM_IDX_LAST;
  assign feat_last_byte = take_data && state_q == tfs_pkg::TFS_ST_FEAT_PAR &&
                          fidx_q == `TFS_FEAT_IDX_LAST;
  assign busy_start = feat_last_byte;
  assign busy_long = lun_hit_q && fstage_q.feature_selector == `TFS_FEAT_TIMING;

  // command sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= tfs_pkg::TFS_ST_IDLE;
    end else if (reset_cmd) begin
      state_q <= tfs_pkg::TFS_ST_IDLE;
    end else begin
      unique case (state_q)
        tfs_pkg::TFS_ST_IDLE: begin
          if (is_cmd && byte_lo == `TFS_OP_TERM_SETUP) begin
            state_q <= tfs_pkg::TFS_ST_TERM_LUN;
          end else if (is_cmd && byte_lo == `TFS_OP_FEAT_WRITE) begin
            state_q <= tfs_pkg::TFS_ST_FEAT_SEL;
          end else if (is_cmd && byte_lo == `TFS_OP_LUN_FEAT_WRITE) begin
            state_q <= tfs_pkg::TFS_ST_FEAT_LUN;
          end
        end
        tfs_pkg::TFS_ST_TERM_LUN: begin
          if (is_addr) begin
            state_q <= tfs_pkg::TFS_ST_TERM_PAY;
          end
        end
        tfs_pkg::TFS_ST_TERM_PAY: begin
          if (term_last) begin
            state_q <= tfs_pkg::TFS_ST_IDLE;
          end
        end
        tfs_pkg::TFS_ST_FEAT_LUN: begin
          if (is_addr) begin
            state_q <= tfs_pkg::TFS_ST_FEAT_SEL;
          end
        end
        tfs_pkg::TFS_ST_FEAT_SEL: begin
          if (is_addr) begin
            state_q <= tfs_pkg::TFS_ST_FEAT_PAR;
          end
        end
        tfs_pkg::TFS_ST_FEAT_PAR: begin
          if (feat_last_byte) begin
            state_q <= tfs_pkg::TFS_ST_BUSY;
          end
        end
        tfs_pkg::TFS_ST_BUSY: begin
          if (!timer_busy) begin
            state_q <= tfs_pkg::TFS_ST_IDLE;
          end
        end
        default: state_q <= tfs_pkg::TFS_ST_IDLE;
      endcase
    end
  end

  // payload byte counters and duplicate tracking
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_q <= 3'h0;
      fidx_q <= 2'h0;
      skip_q <= 1'b0;
    end else if (is_addr || is_cmd) begin
      idx_q <= 3'h0;
      fidx_q <= 2'h0;
      skip_q <= 1'b0;
    end else if (is_data && (state_q == tfs_pkg::TFS_ST_TERM_PAY ||
                             state_q == tfs_pkg::TFS_ST_FEAT_PAR)) begin
      skip_q <= dup_on && !skip_q;
      if (take_data) begin
        idx_q <= idx_q + 3'h1;
        fidx_q <= fidx_q + 2'h1;
      end
    end
  end

  // LUN match: target-wide writes always hit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lun_hit_q <= 1'b0;
    end else if (is_cmd) begin
      lun_hit_q <= 1'b1;
    end else if (is_addr && (state_q == tfs_pkg::TFS_ST_TERM_LUN ||
                             state_q == tfs_pkg::TFS_ST_FEAT_LUN)) begin
      lun_hit_q <= lun_field == own_lun;
    end
  end

  // termination staging; committed as a whole so no half matrix is ever seen
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage_q <= '0;
    end else if (take_data && state_q == tfs_pkg::TFS_ST_TERM_PAY) begin
      unique case (idx_q)
        `TFS_TERM_IDX_M0: stage_q.matrix[7:0] <= byte_lo;
        `TFS_TERM_IDX_M1: stage_q.matrix[15:8] <= byte_lo;
        `TFS_TERM_IDX_DS: stage_q.data_strobe_term_byte <= byte_lo;
        `TFS_TERM_IDX_RE: stage_q.read_enable_term_byte <= byte_lo;
        default: stage_q <= stage_q;
      endcase
    end
  end

  // only power reset clears these; reset opcodes leave them alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      term_q.matrix <= `TFS_MATRIX_RST;
      term_q.data_strobe_term_byte <= `TFS_TERM_BYTE_RST;
      term_q.read_enable_term_byte <= `TFS_TERM_BYTE_RST;
    end else if (take_data && state_q == tfs_pkg::TFS_ST_TERM_PAY &&
                 idx_q == `TFS_TERM_IDX_RE && lun_hit_q) begin
      term_q <= {stage_q.matrix, stage_q.data_strobe_term_byte, byte_lo};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vol_cfg_q <= 1'b0;
    end else if (term_last) begin
      vol_cfg_q <= 1'b1;
    end
  end

  // feature staging and commit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fstage_q <= '0;
    end else if (is_addr && state_q == tfs_pkg::TFS_ST_FEAT_SEL) begin
      fstage_q.feature_selector <= byte_lo;
    end else if (take_data && state_q == tfs_pkg::TFS_ST_FEAT_PAR) begin
      fstage_q.feature_param_bytes[fidx_q * 8 +: 8] <= byte_lo;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      feat_q <= '0;
      feat_pulse_q <= 1'b0;
    end else begin
      feat_pulse_q <= feat_last_byte && lun_hit_q;
      if (feat_last_byte && lun_hit_q) begin
        feat_q.feature_selector <= fstage_q.feature_selector;
        feat_q.feature_param_bytes <= {byte_lo, fstage_q.feature_param_bytes[23:0]};
      end
    end
  end

  // timing-mode feature: interface field and mode number
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      iface_q <= tfs_pkg::TFS_IF_SDR;
      tm_num_q <= `TFS_TM_NUM_RST;
    end else if (full_reset) begin
      iface_q <= tfs_pkg::TFS_IF_SDR;
    end else if (feat_pulse_q && feat_q.feature_selector == `TFS_FEAT_TIMING) begin
      tm_num_q <= feat_q.feature_param_bytes[`TFS_TM_NUM_LSB +: 4];
      // reserved interface code keeps the present interface
      if (feat_q.feature_param_bytes[`TFS_TM_IFACE_LSB +: 2] != 2'b11) begin
        iface_q <= tfs_pkg::tfs_iface_t'(feat_q.feature_param_bytes[`TFS_TM_IFACE_LSB +: 2]);
      end
    end
  end

  tfs_busy_timer u_busy (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(busy_start),
    .long_sel(busy_long),
    .abort(reset_cmd),
    .busy(timer_busy)
  );

  // termination output follows the stored matrix with no extra event
  assign vol_term_active = vol_cfg_q && term_q.matrix[act_volume] &&
                           (act_data_in || act_data_out);
  assign odt_data_strobe_rtt = !vol_term_active ? tfs_pkg::TFS_RTT_OFF :
    act_data_in ? rtt_decode(term_q.data_strobe_term_byte[`TFS_DS_IN_LSB +: 4]) :
    rtt_decode(term_q.data_strobe_term_byte[`TFS_DS_OUT_LSB +: 4]);
  assign odt_read_enable_rtt = (vol_term_active && act_data_out) ?
    rtt_decode(term_q.read_enable_term_byte[`TFS_RE_LSB +: 4]) :
    tfs_pkg::TFS_RTT_OFF;
  assign odt_on = odt_data_strobe_rtt != tfs_pkg::TFS_RTT_OFF ||
                  odt_read_enable_rtt != tfs_pkg::TFS_RTT_OFF;

  assign term_cfg = term_q;
  assign data_iface = iface_q;
  assign timing_mode_num = tm_num_q;
  assign feat_last = feat_q;
  assign feat_write_pulse = feat_pulse_q;
  assign ready = state_q != tfs_pkg::TFS_ST_BUSY;

  a_unconf_no_odt: assert property (@(posedge clk) disable iff (sys_rst)
    !vol_cfg_q |-> !odt_on)
    else $error("termination on before any setup");
  a_matrix_drives_odt: assert property (@(posedge clk) disable iff (sys_rst)
    (vol_term_active && act_data_in &&
     term_q.data_strobe_term_byte[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4}) |-> odt_on)
    else $error("terminator did not terminate");
  a_dup_skip: assert property (@(posedge clk) disable iff (sys_rst)
    (is_data && dup_on && skip_q && state_q == tfs_pkg::TFS_ST_TERM_PAY)
      |=> (!skip_q && $stable(idx_q) && $stable(term_q)))
    else $error("duplicate byte not dropped");
  a_reset_keeps_term: assert property (@(posedge clk) disable iff (sys_rst)
    reset_cmd |=> ($stable(term_q) && $stable(vol_cfg_q)))
    else $error("reset command disturbed termination");
  a_commit_now: assert property (@(posedge clk) disable iff (sys_rst)
    (take_data && state_q == tfs_pkg::TFS_ST_TERM_PAY && idx_q == `TFS_TERM_IDX_RE
     && lun_hit_q) |=> term_q.read_enable_term_byte == $past(byte_lo))
    else $error("termination value not applied at once");
  a_busy_after_param: assert property (@(posedge clk) disable iff (sys_rst)
    (feat_last_byte && !reset_cmd) |=> (!ready && timer_busy))
    else $error("no busy after last parameter");
  a_busy_refuses: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == tfs_pkg::TFS_ST_BUSY && timer_busy && !reset_cmd)
      |=> state_q == tfs_pkg::TFS_ST_BUSY)
    else $error("command taken while busy");
  a_iface_rsvd: assert property (@(posedge clk) disable iff (sys_rst)
    (feat_pulse_q && feat_q.feature_selector == `TFS_FEAT_TIMING && !full_reset &&
     feat_q.feature_param_bytes[5:4] == 2'b11) |=> $stable(iface_q))
    else $error("reserved interface code applied");
  a_full_reset_sdr: assert property (@(posedge clk) disable iff (sys_rst)
    full_reset |=> iface_q == tfs_pkg::TFS_IF_SDR)
    else $error("full reset left double rate on");
endmodule // tfs_cmd_top

// file: bench/tfs_host_model.sv
`timescale 1ns/100ps
`include "tfs_consts.svh"

module tfs_host_model (
  // clock
  input wire logic clk,
  // bus cycles toward the target
  output logic cyc_valid,
  output tfs_pkg::tfs_cyc_t cyc
);
  initial begin
    cyc_valid = 1'b0;
    cyc = {tfs_pkg::TFS_CYC_NONE, 16'h0000};
  end

  // one bus cycle, launched at the falling edge, held over the next rising one
  task automatic put(input tfs_pkg::tfs_cyc_kind_t k, input logic [7:0] b);
    @(negedge clk);
    cyc_valid = 1'b1;
    cyc.kind = k;
    cyc.bus = {8'($urandom), b}; // upper lines carry noise only
  endtask

  // released lines flip, so a stale value never looks valid
  task automatic idle();
    @(negedge clk);
    cyc_valid = 1'b0;
    cyc.kind = tfs_pkg::TFS_CYC_NONE;
    cyc.bus = ~cyc.bus;
  endtask

  task automatic dat(input logic [7:0] b, input logic dup);
    put(tfs_pkg::TFS_CYC_DATA, b);
    if (dup) put(tfs_pkg::TFS_CYC_DATA, b); // double-rate sends each byte twice
  endtask

  // caller keeps this off the first double-rate interface
  task automatic setup(input logic [7:0] lun, input logic [15:0] m, input logic [7:0] ds, re,
                       input logic dup);
    put(tfs_pkg::TFS_CYC_CMD, `TFS_OP_TERM_SETUP);
    put(tfs_pkg::TFS_CYC_ADDR, lun);
    dat(m[7:0], dup);
    dat(m[15:8], dup);
    dat(ds, dup);
    dat(re, dup);
    dat(8'h00, dup);
    dat(8'h00, dup);
    idle();
  endtask

  task automatic feat(input logic [7:0] op, lun, sel, input logic [31:0] p, input logic dup);
    put(tfs_pkg::TFS_CYC_CMD, op);
    if (op == `TFS_OP_LUN_FEAT_WRITE) put(tfs_pkg::TFS_CYC_ADDR, lun);
    put(tfs_pkg::TFS_CYC_ADDR, sel);
    for (int i = 0; i < 4; i++) dat(p[8*i +: 8], dup);
    idle();
  endtask
endmodule // tfs_host_model

// file: bench/tb_termination_feature_setup.sv
`timescale 1ns/100ps
`include "tfs_consts.svh"

module tb_termination_feature_setup;
  logic clk, sys_rst, cyc_valid, act_data_in, act_data_out, odt_on, vol_term_active;
  logic feat_write_pulse, ready;
  tfs_pkg::tfs_cyc_t cyc;
  logic [2:0] own_lun;
  logic [3:0] act_volume, timing_mode_num, tm;
  tfs_pkg::tfs_rtt_t odt_data_strobe_rtt, odt_read_enable_rtt;
  tfs_pkg::tfs_term_cfg_t term_cfg;
  tfs_pkg::tfs_iface_t data_iface;
  tfs_pkg::tfs_feat_t feat_last;
  logic [15:0] m;
  logic [7:0] ds, re;
  logic [31:0] p;
  int n_fail, checks, v;

  tfs_cmd_top uut (.clk(clk), .sys_rst(sys_rst), .cyc_valid(cyc_valid), .cyc(cyc),
    .own_lun(own_lun), .act_volume(act_volume), .act_data_in(act_data_in),
    .act_data_out(act_data_out), .odt_on(odt_on), .odt_data_strobe_rtt(odt_data_strobe_rtt),
    .odt_read_enable_rtt(odt_read_enable_rtt), .term_cfg(term_cfg),
    .vol_term_active(vol_term_active), .data_iface(data_iface),
    .timing_mode_num(timing_mode_num), .feat_last(feat_last),
    .feat_write_pulse(feat_write_pulse), .ready(ready));

  tfs_host_model host (.clk(clk), .cyc_valid(cyc_valid), .cyc(cyc));

  task automatic chk(input logic [39:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // codes above 5h are reserved and read back as off
  function automatic tfs_pkg::tfs_rtt_t rtt_of(input logic [3:0] c);
    return (c <= 4'h5) ? tfs_pkg::tfs_rtt_t'(c[2:0]) : tfs_pkg::TFS_RTT_OFF;
  endfunction

  // bounded wait, so a stuck busy shows as a mismatch instead of a hang
  task automatic wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(ready, 1'b1);
  endtask

  task automatic feat_run(input logic [7:0] op, l, sel, input logic [31:0] pp, input logic hit);
    int n;
    host.feat(op, l, sel, pp, 1'b0);
    chk(ready, 1'b0);
    chk(feat_write_pulse, hit);
    wait_ready(n);
    chk(n >= `TFS_ITC_BUSY_CYC - 1 && n <= `TFS_ITC_BUSY_CYC + 1, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #(8 * 6000);
    n_fail++;
    close_out();
  end

  initial begin
    int n;
    n_fail = 0;
    checks = 0;
    sys_rst = 1'b1;
    own_lun = 3'h0;
    act_volume = 4'h0;
    act_data_in = 1'b0;
    act_data_out = 1'b0;
    void'($urandom(32'h18DE3B49));
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    own_lun = 3'($urandom);
    chk(term_cfg, 32'h0000_0000);
    chk(data_iface, tfs_pkg::TFS_IF_SDR);
    chk(ready, 1'b1);
    // every data/strobe input code, random volumes and output codes
    for (int i = 0; i < 16; i++) begin
      m = 16'($urandom);
      v = $urandom_range(15, 0);
      m[v] = (i != 15);
      ds = {4'($urandom_range(5, 0)), 4'(i)};
      re = {4'h0, 4'($urandom)};
      host.setup({5'h00, own_lun}, m, ds, re, 1'b0);
      chk(term_cfg, {m, ds, re});
      @(negedge clk);
      act_volume = 4'(v);
      act_data_in = 1'b1;
      #1;
      chk(vol_term_active, m[v]);
      if (m[v]) chk(odt_data_strobe_rtt, rtt_of(ds[3:0]));
      if (m[v]) chk(odt_read_enable_rtt, tfs_pkg::TFS_RTT_OFF);
      chk(odt_on, m[v] && rtt_of(ds[3:0]) != tfs_pkg::TFS_RTT_OFF);
      @(negedge clk);
      act_data_in = 1'b0;
      act_data_out = 1'b1;
      #1;
      if (m[v]) chk(odt_data_strobe_rtt, rtt_of(ds[7:4]));
      if (m[v]) chk(odt_read_enable_rtt, rtt_of(re[3:0]));
      chk(odt_on, m[v] && (rtt_of(ds[7:4]) != tfs_pkg::TFS_RTT_OFF ||
                           rtt_of(re[3:0]) != tfs_pkg::TFS_RTT_OFF));
      @(negedge clk);
      act_data_out = 1'b0;
    end
    $display("test done: setup sweep");
    host.setup({5'h00, own_lun ^ 3'h1}, ~m, ~ds, ~re, 1'b0);
    chk(term_cfg, {m, ds, re});
    p = 32'($urandom);
    feat_run(`TFS_OP_LUN_FEAT_WRITE, {5'h00, own_lun ^ 3'h2}, 8'h20, p, 1'b0);
    chk(feat_last, 40'h0);
    tm = 4'($urandom);
    feat_run(`TFS_OP_LUN_FEAT_WRITE, {5'h00, own_lun}, `TFS_FEAT_TIMING, {24'h0, 4'h3, tm}, 1'b1);
    chk(data_iface, tfs_pkg::TFS_IF_SDR);
    chk(timing_mode_num, tm);
    tm = 4'($urandom);
    p = {24'h0, 4'h2, tm};
    feat_run(`TFS_OP_FEAT_WRITE, 8'h00, `TFS_FEAT_TIMING, p, 1'b1);
    chk(feat_last, {`TFS_FEAT_TIMING, p});
    chk(data_iface, tfs_pkg::TFS_IF_DDR_V2);
    chk(timing_mode_num, tm);
    $display("test done: feature writes");
    m = 16'($urandom);
    host.setup({5'h00, own_lun}, m, ds, re, 1'b1);
    chk(term_cfg, {m, ds, re});
    p = 32'($urandom);
    host.feat(`TFS_OP_FEAT_WRITE, 8'h00, 8'h10, p, 1'b1);
    host.setup({5'h00, own_lun}, ~m, ds, re, 1'b1);
    wait_ready(n);
    chk(term_cfg, {m, ds, re});
    chk(feat_last, {8'h10, p});
    $display("test done: doubled bytes");
    host.put(tfs_pkg::TFS_CYC_CMD, `TFS_OP_RESET_FULL);
    host.idle();
    repeat (2) @(negedge clk);
    chk(term_cfg, {m, ds, re});
    chk(data_iface, tfs_pkg::TFS_IF_SDR);
    chk(timing_mode_num, tm);
    // first double-rate interface: feature bytes still come in pairs
    tm = 4'($urandom);
    feat_run(`TFS_OP_FEAT_WRITE, 8'h00, `TFS_FEAT_TIMING, {24'h0, 4'h1, tm}, 1'b1);
    chk(data_iface, tfs_pkg::TFS_IF_DDR_V1);
    chk(timing_mode_num, tm);
    p = 32'($urandom);
    host.feat(`TFS_OP_FEAT_WRITE, 8'h00, 8'h10, p, 1'b1);
    wait_ready(n);
    chk(feat_last, {8'h10, p});
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    chk(term_cfg, 32'h0000_0000);
    chk(data_iface, tfs_pkg::TFS_IF_SDR);
    $display("test done: resets");
    close_out();
  end
endmodule // tb_termination_feature_setup
